// ### fault_status_pkg.sv
// Purpose: shared constants and carrier types for the fault status readback bank
// Assumes: 8-bit registers on an 8-bit register address of the control port
// Notes:   struct fields are ordered msb first, so a struct packs straight into its register byte
package fault_status_pkg;

  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] LATCHED_ANALOG_VAD_BIAS_IRQ_OFS = 8'h3b; // self-clearing latched events
  localparam logic [7:0] LIVE_CLOCK_BOOST_IRQ_OFS        = 8'h3c; // live clock and boost
  localparam logic [7:0] LIVE_CHANNEL_FAULT_SUMMARY_OFS  = 8'h3d; // live channel summary
  localparam logic [7:0] LIVE_INPUT1_FAULTS_OFS          = 8'h3e; // live input channel 1
  localparam logic [7:0] LIVE_INPUT2_FAULTS_OFS          = 8'h3f; // live input channel 2
  localparam logic [7:0] LIVE_OUTPUT1_FAULTS_OFS         = 8'h40; // live output channel 1
  localparam logic [7:0] LIVE_OUTPUT2_FAULTS_OFS         = 8'h41; // live output channel 2
  localparam logic [7:0] LIVE_INPUT_VOLT_HEADSET_IRQ_OFS = 8'h42; // live over-voltage and headset

  // ------------------------------------------------------------------
  // reset values and widths
  // ------------------------------------------------------------------
  localparam logic [7:0] STATUS_RESET_VAL = 8'h00; // every register reads this after reset
  localparam int         REG_W            = 8;     // register data width
  localparam int         SYNC_STAGES      = 2;     // flops in each input synchroniser

  // ------------------------------------------------------------------
  // field layouts
  // ------------------------------------------------------------------
  // latched event sources, bit 7 down to bit 0
  typedef struct packed {
    logic analog_up;       // general_analog_input above upper threshold
    logic analog_low;      // general_analog_input below lower threshold
    logic vad_power_up;    // voice_activity_detector power-up detect
    logic vad_power_down;  // voice_activity_detector power-down detect
    logic bias_short;      // mic bias short circuit
    logic bias_high_cur;   // mic bias high current
    logic bias_low_cur;    // mic bias low current
    logic bias_over_volt;  // mic bias over voltage
  } latched_events_s;

  // clock and boost conditions, bits 7 down to 3
  typedef struct packed {
    logic clock_error;       // clock error
    logic pll_lock;          // pll lock
    logic boost_over_temp;   // boost over temperature
    logic boost_over_cur;    // boost over current
    logic boost_mode_event;  // boost mode event
  } clock_boost_s;

  // one input channel, bits 7 down to 0
  typedef struct packed {
    logic open_inputs;       // inputs open
    logic inputs_shorted;    // terminals shorted to each other
    logic positive_gnd;      // positive_input to ground
    logic negative_gnd;      // negative_input to ground
    logic positive_bias;     // positive_input to mic bias
    logic negative_bias;     // negative_input to mic bias
    logic positive_battery;  // positive_input to battery input
    logic negative_battery;  // negative_input to battery input
  } input_faults_s;

  // one output channel, bits 7 down to 4
  typedef struct packed {
    logic positive_short;  // positive output pin short
    logic negative_short;  // negative output pin short
    logic positive_vgnd;   // positive_driver virtual ground fault
    logic negative_vgnd;   // negative_driver virtual ground fault
  } output_faults_s;

  // every condition arriving from the analog detectors
  typedef struct packed {
    latched_events_s events;               // latched register sources
    clock_boost_s    clk_boost;            // clock and boost
    input_faults_s   in1;                  // input channel 1
    input_faults_s   in2;                  // input channel 2
    output_faults_s  out1;                 // output channel 1
    output_faults_s  out2;                 // output channel 2
    logic            regulator_short_live; // analog_regulator short circuit
    logic            vbat_short_low;       // short to battery while battery below bias
    logic [6:0]      volt_headset;         // over-voltage and headset bits 7 down to 1
  } fault_inputs_s;

  localparam int FAULT_W = $bits(fault_inputs_s); // synchroniser width

endpackage : fault_status_pkg

// ### fault_status_readback_bank.sv
// Purpose: read-only fault and interrupt status bank behind the control port
// Assumes: detector conditions are levels from the analog side, asynchronous to ref_clk;
//          the control port read strobe is synchronous to ref_clk
// Notes:   read data is registered and appears one cycle after the strobe
`timescale 1ns/1ps

// Summary of operation
// - latched bit7 upper, bit6 lower analog threshold
// - latched bit5 vad up, bit4 vad down
// - latched bits3..0 bias short, high, low, overvolt
// - latched flags hold until cleared by hardware
// - live bit7 clock error, bit6 pll lock
// - live bits5..3 boost temp, current, mode
// - summary bits7..4 any fault per channel
// - summary bit3 battery short below bias
// - input bit7 open, bit6 terminals shorted
// - input bit5/4 positive/negative to ground
// - input bit3/2 positive/negative to bias
// - input bit1/0 positive/negative to battery
// - output bit7/6 positive/negative pin short
// - output bit5/4 positive/negative virtual ground
// - output2 bit0 regulator short fault
// - live registers follow present conditions
// - all registers 8-bit, read-only, reset zero
module fault_status_readback_bank
  import fault_status_pkg::*;
#(
  parameter int ADDR_W = 8  // control port register address width
)(
  input  wire logic                                ref_clk,
  input  wire logic                                reset_n,
  input  wire fault_status_pkg::fault_inputs_s     fault_in,
  input  wire logic                                rd_en,
  input  wire logic [ADDR_W-1:0]                   rd_addr,
  output logic      [fault_status_pkg::REG_W-1:0]  rd_data,
  output logic                                     rd_valid
);
  import fault_status_pkg::*;

  // ------------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------------
  // offsets are eight bits wide, so a narrower address cannot reach them
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  logic [FAULT_W-1:0] sync1_ff;  // first stage, read only by second stage
  logic [FAULT_W-1:0] sync2_ff;  // second stage, safe to use
  fault_inputs_s      cond;      // synchronised conditions

  // two flops per detector bit
  for (genvar i = 0; i < FAULT_W; i++) begin : g_sync
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
      if (!reset_n)
      begin
        sync1_ff[i] <= 1'b0;
        sync2_ff[i] <= 1'b0;
      end
      else
      begin
        sync1_ff[i] <= fault_in[i];
        sync2_ff[i] <= sync1_ff[i];
      end
    end
  end

  assign cond = fault_inputs_s'(sync2_ff);

  // ------------------------------------------------------------------
  // read decode
  // ------------------------------------------------------------------
  logic [7:0] addr8;        // offset part of the address
  logic       hi_zero;      // upper address bits clear
  logic       hit_latched;  // read of the latched register
  logic       clr_latched;  // clear-on-read strobe

  assign addr8       = rd_addr[7:0];
  assign hi_zero     = (rd_addr >> 8) == '0;
  assign hit_latched = hi_zero && (addr8 == LATCHED_ANALOG_VAD_BIAS_IRQ_OFS);
  assign clr_latched = rd_en && hit_latched;

  // ------------------------------------------------------------------
  // latched self-clearing register
  // ------------------------------------------------------------------
  logic [7:0] latched_ff;      // latched event flags
  logic [7:0] nxt_latched;     // next latched value
  logic [7:0] event_bits;      // sources packed into register order

  // threshold, vad and bias events packed by struct order
  assign event_bits  = cond.events;
  // a read clears, a present event always wins over the clear
  assign nxt_latched = event_bits | (latched_ff & ~{8{clr_latched}});

  // latch holds until hardware clears it after a read
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      latched_ff <= STATUS_RESET_VAL;
    else
      latched_ff <= nxt_latched;
  end

  // ------------------------------------------------------------------
  // live registers
  // ------------------------------------------------------------------
  logic [7:0] nxt_live_cb;        // clock and boost
  logic [7:0] nxt_live_sum;       // channel summary
  logic [7:0] nxt_live_in1;       // input channel 1
  logic [7:0] nxt_live_in2;       // input channel 2
  logic [7:0] nxt_live_out1;      // output channel 1
  logic [7:0] nxt_live_out2;      // output channel 2
  logic [7:0] nxt_live_vh;        // over-voltage and headset
  logic       out2_any;           // any output channel 2 fault
  logic [7:0] live_cb_ff;
  logic [7:0] live_sum_ff;
  logic [7:0] live_in1_ff;
  logic [7:0] live_in2_ff;
  logic [7:0] live_out1_ff;
  logic [7:0] live_out2_ff;
  logic [7:0] live_vh_ff;

  // clock bits on top, boost bits next, reserved low bits zero
  assign nxt_live_cb   = {cond.clk_boost, 3'h0};
  // per-pin input faults in struct order
  assign nxt_live_in1  = cond.in1;
  assign nxt_live_in2  = cond.in2;
  // output shorts and virtual ground, reserved low bits zero
  assign nxt_live_out1 = {cond.out1, 4'h0};
  // regulator short on bit 0 of output channel 2
  assign nxt_live_out2 = {cond.out2, 3'h0, cond.regulator_short_live};
  assign nxt_live_vh   = {cond.volt_headset, 1'b0};
  // the regulator short is counted as an output channel 2 fault
  assign out2_any      = (|cond.out2) | cond.regulator_short_live;
  // channel summary and battery-below-bias short
  assign nxt_live_sum  = {|cond.in1, |cond.in2, |cond.out1, out2_any, cond.vbat_short_low, 3'h0};

  // live copies refresh every cycle, nothing is held
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      live_cb_ff   <= STATUS_RESET_VAL;
      live_sum_ff  <= STATUS_RESET_VAL;
      live_in1_ff  <= STATUS_RESET_VAL;
      live_in2_ff  <= STATUS_RESET_VAL;
      live_out1_ff <= STATUS_RESET_VAL;
      live_out2_ff <= STATUS_RESET_VAL;
      live_vh_ff   <= STATUS_RESET_VAL;
    end
    else
    begin
      live_cb_ff   <= nxt_live_cb;
      live_sum_ff  <= nxt_live_sum;
      live_in1_ff  <= nxt_live_in1;
      live_in2_ff  <= nxt_live_in2;
      live_out1_ff <= nxt_live_out1;
      live_out2_ff <= nxt_live_out2;
      live_vh_ff   <= nxt_live_vh;
    end
  end

  // ------------------------------------------------------------------
  // read mux and registered answer
  // ------------------------------------------------------------------
  logic [7:0] rd_mux;       // selected register value
  logic [7:0] rd_data_ff;   // registered read data
  logic       rd_valid_ff;  // one-cycle answer strobe

  // unmapped offsets read zero; no write path exists
  assign rd_mux = !hi_zero                                   ? STATUS_RESET_VAL :
                  (addr8 == LATCHED_ANALOG_VAD_BIAS_IRQ_OFS) ? latched_ff :
                  (addr8 == LIVE_CLOCK_BOOST_IRQ_OFS)        ? live_cb_ff :
                  (addr8 == LIVE_CHANNEL_FAULT_SUMMARY_OFS)  ? live_sum_ff :
                  (addr8 == LIVE_INPUT1_FAULTS_OFS)          ? live_in1_ff :
                  (addr8 == LIVE_INPUT2_FAULTS_OFS)          ? live_in2_ff :
                  (addr8 == LIVE_OUTPUT1_FAULTS_OFS)         ? live_out1_ff :
                  (addr8 == LIVE_OUTPUT2_FAULTS_OFS)         ? live_out2_ff :
                  (addr8 == LIVE_INPUT_VOLT_HEADSET_IRQ_OFS) ? live_vh_ff :
                                                               STATUS_RESET_VAL;

  // capture on the strobe, data holds until the next read
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_data_ff  <= STATUS_RESET_VAL;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      rd_valid_ff <= rd_en;
      if (rd_en)
        rd_data_ff <= rd_mux;
    end
  end

  assign rd_data  = rd_data_ff;
  assign rd_valid = rd_valid_ff;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_latch_sets_on_event: assert property (
    (event_bits != 8'h00) |=> ((latched_ff & $past(event_bits)) == $past(event_bits)))
    else $error("latched flag missed its event");

  a_latch_holds_unread: assert property (
    !clr_latched |=> ((latched_ff & $past(latched_ff)) == $past(latched_ff)))
    else $error("latched flag dropped without a read");

  a_read_clears_idle: assert property (
    (clr_latched && (event_bits == 8'h00)) |=> (latched_ff == 8'h00))
    else $error("latched register not cleared by read");

  a_read_returns_latch: assert property (
    clr_latched |=> (rd_valid && (rd_data == $past(latched_ff))))
    else $error("latched read data wrong");

  a_cb_follows_cond: assert property (
    ##1 (live_cb_ff == {$past(cond.clk_boost), 3'h0}))
    else $error("clock boost register not following condition");

  a_live_not_held: assert property (
    (cond.in1 == 8'h00) [*2] |-> (live_in1_ff == 8'h00))
    else $error("input channel 1 held a past fault");

  a_summary_in1: assert property (
    ##1 (live_sum_ff[7] == $past(|cond.in1)))
    else $error("summary input channel 1 bit wrong");

  a_summary_vbat: assert property (
    ##1 (live_sum_ff[3] == $past(cond.vbat_short_low)))
    else $error("summary battery short bit wrong");

  a_out2_regulator: assert property (
    ##1 (live_out2_ff[0] == $past(cond.regulator_short_live)))
    else $error("regulator short bit wrong");

  a_reserved_read_zero: assert property (
    (rd_en && hi_zero && (addr8 == LIVE_OUTPUT1_FAULTS_OFS)) |=> (rd_data[3:0] == 4'h0))
    else $error("reserved bits read nonzero");

  a_unmapped_reads_zero: assert property (
    (rd_en && (!hi_zero || (addr8 < LATCHED_ANALOG_VAD_BIAS_IRQ_OFS) ||
     (addr8 > LIVE_INPUT_VOLT_HEADSET_IRQ_OFS))) |=> (rd_data == 8'h00))
    else $error("unmapped read nonzero");

  a_valid_one_cycle: assert property (
    rd_en |=> rd_valid)
    else $error("read answer missing");

  a_valid_drops: assert property (
    !rd_en |=> !rd_valid)
    else $error("read answer without a strobe");

  a_data_holds: assert property (
    !rd_en |=> $stable(rd_data))
    else $error("read data changed without a read");

  a_summary_in2: assert property (
    ##1 (live_sum_ff[6] == $past(|cond.in2)))
    else $error("summary input channel 2 bit wrong");

  a_summary_out1: assert property (
    ##1 (live_sum_ff[5] == $past(|cond.out1)))
    else $error("summary output channel 1 bit wrong");

  a_summary_out2: assert property (
    ##1 (live_sum_ff[4] == $past((|cond.out2) | cond.regulator_short_live)))
    else $error("summary output channel 2 bit wrong");

  a_in1_follows: assert property (
    ##1 (live_in1_ff == $past(cond.in1)))
    else $error("input channel 1 register not following condition");

  a_in2_follows: assert property (
    ##1 (live_in2_ff == $past(cond.in2)))
    else $error("input channel 2 register not following condition");

  a_out1_follows: assert property (
    ##1 (live_out1_ff == {$past(cond.out1), 4'h0}))
    else $error("output channel 1 register not following condition");

  a_out2_follows: assert property (
    ##1 (live_out2_ff[7:4] == $past(cond.out2)))
    else $error("output channel 2 register not following condition");

  a_vh_follows: assert property (
    ##1 (live_vh_ff == {$past(cond.volt_headset), 1'b0}))
    else $error("over-voltage and headset register not following condition");

  c_event_then_read: cover property (
    (event_bits != 8'h00) ##[1:20] clr_latched);
  c_set_beats_clear: cover property (
    clr_latched && (event_bits != 8'h00));
  c_live_fault_read: cover property (
    (|cond.out1) ##1 (rd_en && addr8 == LIVE_OUTPUT1_FAULTS_OFS));
  c_unmapped_read: cover property (
    rd_en && (addr8 == 8'h43));
  c_event_reread: cover property (
    (clr_latched && (latched_ff != 8'h00)) ##2 clr_latched);

endmodule : fault_status_readback_bank

// ### status_host_model.sv
// Purpose: host side of the control port, reading the fault status bank
// Assumes: one strobe per read, driven at the falling edge of ref_clk
// Notes:   the host only reads, so reserved bits keep their reset value
`timescale 1ns/1ps
module status_host_model
  import fault_status_pkg::*;
(
  input  wire logic                            ref_clk,
  input  wire logic                            rd_valid,
  input  wire logic [fault_status_pkg::REG_W-1:0] rd_data,
  output logic                                 rd_en,
  output logic      [7:0]                      rd_addr
);
  // ------------------------------------------------------------------
  // idle state of the port
  // ------------------------------------------------------------------
  initial
  begin
    rd_en   = 1'b0;
    rd_addr = 8'h00;
  end

  // ------------------------------------------------------------------
  // one read: strobe for one cycle, answer taken while rd_valid stands
  // ------------------------------------------------------------------
  task automatic read_reg(input logic [7:0] addr, output logic [REG_W-1:0] data, output logic ok);
    @(negedge ref_clk);
    rd_en   = 1'b1;          // host side only ever reads
    rd_addr = addr;
    @(negedge ref_clk);
    ok      = rd_valid;      // answer stands half a cycle after the taking edge
    data    = rd_data;
    rd_en   = 1'b0;
    rd_addr = ~addr;         // released address shows no stale value
  endtask : read_reg
endmodule : status_host_model

// ### test_fault_status_readback_bank.sv
// Purpose: self-checking bench for the fault status readback bank
// Assumes: fault levels are held at least four cycles before a read
// Notes:   random fault patterns come from a fixed xorshift seed
`timescale 1ns/1ps
module test_fault_status_readback_bank;
  import fault_status_pkg::*;
  logic                ref_clk;
  logic                reset_n;
  logic                rd_en;
  logic                rd_valid;
  logic [7:0]          rd_addr;
  logic [REG_W-1:0]    rd_data;
  fault_inputs_s       fault_in;
  int                  errors;
  int                  samples_checked;
  int                  cycles;
  logic [31:0]         seed;      // xorshift state
  logic [7:0]          exp_latch; // expected latched register

  // ------------------------------------------------------------------
  // clock, device and host
  // ------------------------------------------------------------------
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;

  fault_status_readback_bank fault_status_readback_bank_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .fault_in(fault_in), .rd_en(rd_en),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid));
  status_host_model status_host_model_inst (
    .ref_clk(ref_clk), .rd_valid(rd_valid), .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr));

  // ------------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  function logic [63:0] rnd64();
    seed = xorshift(seed);
    rnd64[31:0] = seed;
    seed = xorshift(seed);
    rnd64[63:32] = seed;
  endfunction : rnd64

  // register byte expected for a held fault pattern
  function automatic logic [7:0] exp_reg(input fault_inputs_s f, input logic [7:0] lat, input logic [7:0] a);
    case (a)
      LATCHED_ANALOG_VAD_BIAS_IRQ_OFS: return lat;
      LIVE_CLOCK_BOOST_IRQ_OFS:        return {f.clk_boost, 3'h0};
      LIVE_CHANNEL_FAULT_SUMMARY_OFS:  return {|f.in1, |f.in2, |f.out1, (|f.out2) | f.regulator_short_live,
                                               f.vbat_short_low, 3'h0};
      LIVE_INPUT1_FAULTS_OFS:          return f.in1;
      LIVE_INPUT2_FAULTS_OFS:          return f.in2;
      LIVE_OUTPUT1_FAULTS_OFS:         return {f.out1, 4'h0};
      LIVE_OUTPUT2_FAULTS_OFS:         return {f.out2, 3'h0, f.regulator_short_live};
      LIVE_INPUT_VOLT_HEADSET_IRQ_OFS: return {f.volt_headset, 1'b0};
      default:                         return 8'h00;
    endcase
  endfunction : exp_reg

  // ------------------------------------------------------------------
  // comparison and bus tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic read_check(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    status_host_model_inst.read_reg(a, d, ok);
    check("rd_valid", 8'h01, {7'h00, ok});
    check($sformatf("register %h", a), exp, d);
  endtask : read_check

  // hold a pattern long enough to pass the synchroniser
  task automatic apply(input fault_inputs_s f);
    @(negedge ref_clk);
    fault_in  = f;
    exp_latch = exp_latch | f.events;
    repeat (4) @(negedge ref_clk);
  endtask : apply

  // read every register plus the unmapped neighbours on each side
  task automatic sweep();
    for (int a = 8'h3a; a <= 8'h43; a++)
    begin
      read_check(8'(a), exp_reg(fault_in, exp_latch, 8'(a)));
      if (a == 8'h3b)
        exp_latch = fault_in.events; // present events survive the read
    end
  endtask : sweep

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : complete_run

  // ------------------------------------------------------------------
  // hang guard
  // ------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial
  begin
    fault_inputs_s f;
    reset_n = 1'b0;
    fault_in = '0;
    seed = 32'h0000315f;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    exp_latch = 8'h00;
    repeat (6) @(negedge ref_clk);
    reset_n = 1'b1;
    sweep();
    // a short event per latched bit stays until read, then clears
    for (int b = 0; b < 8; b++)
    begin
      f = '0;
      f.events = 8'h01 << b;
      apply(f);
      apply('0);
      read_check(LATCHED_ANALOG_VAD_BIAS_IRQ_OFS, 8'h01 << b);
      read_check(LATCHED_ANALOG_VAD_BIAS_IRQ_OFS, 8'h00);
    end
    // an event still present at the read keeps its bit
    f = '0;
    f.events = 8'h81;
    exp_latch = 8'h00;
    apply(f);
    read_check(LATCHED_ANALOG_VAD_BIAS_IRQ_OFS, 8'h81);
    read_check(LATCHED_ANALOG_VAD_BIAS_IRQ_OFS, 8'h81);
    apply('0);
    read_check(LATCHED_ANALOG_VAD_BIAS_IRQ_OFS, 8'h81);
    read_check(LATCHED_ANALOG_VAD_BIAS_IRQ_OFS, 8'h00);
    exp_latch = 8'h00;
    // sparse random fault patterns across all registers
    for (int n = 0; n < 40; n++)
    begin
      f = fault_inputs_s'(46'(rnd64() & rnd64() & rnd64()));
      apply(f);
      sweep();
    end
    complete_run();
  end
endmodule : test_fault_status_readback_bank
